// file: verilog/reset_init_pkg.sv
// Operation
// - Power-on reset clears timeout_flag and power_down_flag to zero.
// - External pin reset in normal operation keeps both flags unchanged.
// - Watchdog reset in normal operation sets timeout_flag, keeps power_down_flag.
// - Watchdog reset while powered down sets both flags to one.
// - Both flags are bits of the status register, readable by software.
// - Every reset except a watchdog reset while powered down clears all interrupt enable controls.
// - Watchdog counter clears on reset and restarts counting at once.
// - Both timer/event counters stop with run controls deasserted after reset.
// - Port data and direction registers load all ones, pins become inputs.
// - Stack pointer points at top of call stack after reset.
// - Sleep/idle watchdog reset keeps most registers; others load defaults.
// - Derive 32768Hz reference from the 10 MHz clock; the system clock is given only as an enable, sys_clk_en.
// - Separate watchdog oscillator independent of crystal-derived system clock.
// - Any reset forces program counter to zero.
package reset_init_pkg;
	localparam int          PC_W          = 12;
	localparam int          SP_W          = 3;
	localparam int          WDT_W         = 8;
	localparam logic [7:0]  PORT_RESET    = 8'hff;
	localparam logic [7:0]  WDT_SEL_RESET = 8'h07;
	localparam logic [11:0] PC_RESET      = 12'h000;
	localparam logic [2:0]  SP_TOP        = 3'h0;
	localparam logic [3:0]  INT_EN_RESET  = 4'h0;
	localparam int          REF_HZ        = 32768;
	localparam int          SYS_HZ        = 3580000;
	// Reference half-period in 10 MHz cycles: 10e6/(2*32768) rounds down to whole cycles
	localparam int          CLK_HZ        = 10000000;
	localparam int          REF_DIV       = CLK_HZ / (2 * REF_HZ);
	localparam int          SYS_DIV       = 1;
	localparam int          WDOG_OSC_DIV  = 325;
	localparam int          DIV_W         = 9;

	typedef enum logic [3:0] {
		ST_RUN   = 4'b0001,
		ST_POR   = 4'b0010,
		ST_APPLY = 4'b0100,
		ST_HOLD  = 4'b1000
	} seq_state_t;
endpackage

// file: verilog/clock_divider.sv
`timescale 1ns/1ns
// Free running toggle divider; output flips every div clock cycles
module clock_divider (
	// Clock and reset
	input  wire logic             clk_sys,
	input  wire logic             rstn,
	input  wire logic             ce,
	// Control
	input  wire logic [8:0]       div,
	// Output
	output logic                  clk_out
);
	logic [8:0] count;
	wire        wrap = (count >= div - 9'h001);

	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			count   <= 9'h000;
			clk_out <= 1'b0;
		end else if (ce) begin
			count   <= wrap ? 9'h000 : count + 9'h001;
			clk_out <= wrap ? ~clk_out : clk_out;
		end
	end
endmodule // clock_divider

// file: verilog/reset_state_initialiser.sv
`timescale 1ns/1ns
module reset_state_initialiser (
	// Clock, reset, enable
	input  wire logic        clk_sys,
	input  wire logic        rstn,
	input  wire logic        ce,
	// Reset sources
	input  wire logic        external_reset_pin_n,
	input  wire logic        watchdog_overflow,
	input  wire logic        power_down,
	// Software watchdog clear
	input  wire logic        watchdog_clear,
	// Status and reset-cause flags
	output logic             timeout_flag,
	output logic             power_down_flag,
	output logic [7:0]       status_reg,
	output logic             core_reset,
	// Initial state
	output logic [11:0]      program_counter,
	output logic [2:0]       stack_pointer,
	output logic [3:0]       interrupt_enable,
	output logic [1:0]       timer_run,
	output logic [7:0]       port_data,
	output logic [7:0]       port_dir,
	output logic [7:0]       watchdog_select_reg,
	output logic [7:0]       watchdog_counter,
	// Clocks
	output logic             ref_clk,
	output logic             sys_clk_en,
	output logic             watchdog_osc
);
	reset_init_pkg::seq_state_t state;
	reset_init_pkg::seq_state_t next_state;

	// Pin synchroniser; first stage read only by the second
	logic pin_meta;
	logic pin_sync;
	logic pin_prev;
	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			pin_meta <= 1'b1;
			pin_sync <= 1'b1;
			pin_prev <= 1'b1;
		end else if (ce) begin
			pin_meta <= external_reset_pin_n;
			pin_sync <= pin_meta;
			pin_prev <= pin_sync;
		end
	end

	wire pin_fall    = pin_prev & ~pin_sync;
	wire pin_active  = ~pin_sync;
	wire wdog_event  = watchdog_overflow & (state == reset_init_pkg::ST_RUN);
	wire pin_event   = pin_fall & (state == reset_init_pkg::ST_RUN);
	wire any_event   = wdog_event | pin_event;

	// Cause latched at start so the apply step sees a stable choice
	logic cause_wdog;
	logic was_down;
	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			cause_wdog <= 1'b0;
			was_down   <= 1'b0;
		end else if (ce && any_event) begin
			cause_wdog <= wdog_event;
			was_down   <= power_down;
		end
	end

	// Sleep/idle watchdog reset keeps peripheral registers; others load defaults
	wire preserve = cause_wdog & was_down;

	always_comb begin
		next_state = state;
		case (state)
			reset_init_pkg::ST_POR:   next_state = reset_init_pkg::ST_HOLD;
			reset_init_pkg::ST_RUN:   next_state = any_event ? reset_init_pkg::ST_APPLY
			                                                 : reset_init_pkg::ST_RUN;
			reset_init_pkg::ST_APPLY: next_state = reset_init_pkg::ST_HOLD;
			reset_init_pkg::ST_HOLD:  next_state = pin_active ? reset_init_pkg::ST_HOLD
			                                                  : reset_init_pkg::ST_RUN;
			default:                  next_state = reset_init_pkg::ST_POR;
		endcase
	end

	always_ff @(posedge clk_sys) begin
		if (!rstn)
			state <= reset_init_pkg::ST_POR;
		else if (ce)
			state <= next_state;
	end

	wire is_por   = (state == reset_init_pkg::ST_POR);
	wire is_apply = (state == reset_init_pkg::ST_APPLY);
	wire load_all = is_por | (is_apply & ~preserve);

	// Reset-cause flags
	wire next_timeout = is_por ? 1'b0 :
	                    (is_apply & cause_wdog) ? 1'b1 :
	                    timeout_flag;
	wire next_pdf     = is_por ? 1'b0 :
	                    (is_apply & preserve) ? 1'b1 :
	                    power_down_flag;

	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			timeout_flag    <= 1'b0;
			power_down_flag <= 1'b0;
			status_reg      <= 8'h00;
		end else if (ce) begin
			timeout_flag    <= next_timeout;
			power_down_flag <= next_pdf;
			status_reg      <= {2'b00, next_timeout, next_pdf, 4'h0};
		end
	end

	// Core held in reset from the event until the pin is released
	always_ff @(posedge clk_sys) begin
		if (!rstn)
			core_reset <= 1'b1;
		else if (ce)
			core_reset <= (next_state != reset_init_pkg::ST_RUN);
	end

	// Program counter and stack pointer clear on every reset kind
	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			program_counter <= reset_init_pkg::PC_RESET;
			stack_pointer   <= reset_init_pkg::SP_TOP;
		end else if (ce && (is_por || is_apply)) begin
			program_counter <= reset_init_pkg::PC_RESET;
			stack_pointer   <= reset_init_pkg::SP_TOP;
		end
	end

	// Peripheral defaults, skipped for a watchdog reset while powered down
	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			interrupt_enable    <= reset_init_pkg::INT_EN_RESET;
			timer_run           <= 2'b00;
			port_data           <= reset_init_pkg::PORT_RESET;
			port_dir            <= reset_init_pkg::PORT_RESET;
			watchdog_select_reg <= reset_init_pkg::WDT_SEL_RESET;
		end else if (ce && load_all) begin
			interrupt_enable    <= reset_init_pkg::INT_EN_RESET;
			timer_run           <= 2'b00;
			port_data           <= reset_init_pkg::PORT_RESET;
			port_dir            <= reset_init_pkg::PORT_RESET;
			watchdog_select_reg <= reset_init_pkg::WDT_SEL_RESET;
		end
	end

	// Clock sources
	logic ref_tog;
	logic wdog_tog;
	clock_divider u_ref_div (
		.clk_sys (clk_sys),
		.rstn    (rstn),
		.ce      (ce),
		.div     (9'(reset_init_pkg::REF_DIV)),
		.clk_out (ref_tog)
	);
	// Own divider chain, never gated by the system clock enable path
	clock_divider u_wdog_div (
		.clk_sys (clk_sys),
		.rstn    (rstn),
		.ce      (ce),
		.div     (9'(reset_init_pkg::WDOG_OSC_DIV)),
		.clk_out (wdog_tog)
	);

	logic wdog_prev;
	wire  wdog_tick = wdog_tog & ~wdog_prev;
	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			ref_clk      <= 1'b0;
			watchdog_osc <= 1'b0;
			wdog_prev    <= 1'b0;
			sys_clk_en   <= 1'b0;
		end else if (ce) begin
			ref_clk      <= ref_tog;
			watchdog_osc <= wdog_tog;
			wdog_prev    <= wdog_tog;
			sys_clk_en   <= ~power_down & ~core_reset;
		end
	end

	// Watchdog counter: cleared at reset, counts straight after
	always_ff @(posedge clk_sys) begin
		if (!rstn)
			watchdog_counter <= 8'h00;
		else if (ce) begin
			if (is_por || is_apply || watchdog_clear)
				watchdog_counter <= 8'h00;
			else if (wdog_tick)
				watchdog_counter <= watchdog_counter + 8'h01;
		end
	end
endmodule // reset_state_initialiser

// file: test/reset_init_checker.sv
`timescale 1ns/1ns
module reset_init_checker (
	// Clock and sources
	input wire logic        clk_sys,
	input wire logic        rstn,
	input wire logic        ce,
	input wire logic        watchdog_overflow,
	input wire logic        power_down,
	// Device outputs
	input wire logic        core_reset,
	input wire logic        timeout_flag,
	input wire logic        power_down_flag,
	input wire logic [7:0]  status_reg,
	input wire logic [11:0] program_counter,
	input wire logic [2:0]  stack_pointer,
	input wire logic [3:0]  interrupt_enable,
	input wire logic [1:0]  timer_run,
	input wire logic [7:0]  port_dir,
	input wire logic [7:0]  watchdog_select_reg
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rstn);
	wire wd_go = ce && watchdog_overflow && !core_reset;
	a_wd_sets_timeout: assert property (wd_go |=> core_reset ##1 timeout_flag ##1 !core_reset)
		else $error("watchdog event sequence wrong");
	a_wd_pd_set: assert property (wd_go && power_down |-> ##2 power_down_flag)
		else $error("power-down flag not set");
	a_wd_pd_keep: assert property (wd_go && !power_down |-> ##2 $stable(power_down_flag))
		else $error("power-down flag changed");
	a_pin_keeps_flags: assert property ($rose(core_reset) && !$past(watchdog_overflow)
		|=> $stable(timeout_flag) && $stable(power_down_flag)) else $error("pin reset moved flags");
	a_status_bits: assert property ($stable(timeout_flag) && $stable(power_down_flag)
		|-> status_reg == {2'h0, timeout_flag, power_down_flag, 4'h0}) else $error("status map");
	a_pc_sp_zero: assert property ($rose(core_reset) |=> program_counter == 12'h000
		&& stack_pointer == reset_init_pkg::SP_TOP) else $error("pc or sp not cleared");
	a_defaults_load: assert property ($rose(core_reset) && !($past(watchdog_overflow)
		&& $past(power_down)) |=> interrupt_enable == 4'h0 && timer_run == 2'h0
		&& port_dir == 8'hff && watchdog_select_reg == 8'h07) else $error("defaults not loaded");
	a_sleep_keeps: assert property ($rose(core_reset) && $past(watchdog_overflow)
		&& $past(power_down) |=> $stable(port_dir) && $stable(watchdog_select_reg))
		else $error("sleep reset changed registers");
	c_wd_sleep: cover property (wd_go && power_down);
	c_wd_run: cover property (wd_go && !power_down);
	c_pin: cover property ($rose(core_reset) && !$past(watchdog_overflow));
endmodule // reset_init_checker

bind reset_state_initialiser reset_init_checker chk_u (.clk_sys, .rstn, .ce, .watchdog_overflow,
	.power_down, .core_reset, .timeout_flag, .power_down_flag, .status_reg, .program_counter,
	.stack_pointer, .interrupt_enable, .timer_run, .port_dir, .watchdog_select_reg);

// file: test/reset_source_model.sv
`timescale 1ns/1ns
// Reset pin circuit with pull-up, and watchdog overflow source
module reset_source_model (
	// Clock and commands
	input wire logic clk_sys,
	input wire logic pin_hold,
	input wire logic wd_fire,
	// Toward the device
	output logic     external_reset_pin_n,
	output logic     watchdog_overflow
);
	initial external_reset_pin_n = 1'b1;
	initial watchdog_overflow = 1'b0;
	// Released pin goes to the pull-up level
	always @(negedge clk_sys) begin
		external_reset_pin_n <= !pin_hold;
		watchdog_overflow <= wd_fire;
	end
endmodule // reset_source_model

// file: test/tb.sv
`timescale 1ns/1ns
module tb;
	logic        clk_sys = 0, rstn = 0, ce = 1, power_down = 0, watchdog_clear = 0;
	logic        pin_hold = 0, wd_fire = 0, wd, pd;
	logic        timeout_flag, power_down_flag, core_reset, ref_clk, sys_clk_en, watchdog_osc;
	logic [7:0]  status_reg, port_data, port_dir, watchdog_select_reg, watchdog_counter;
	logic [11:0] program_counter;
	logic [2:0]  stack_pointer;
	logic [3:0]  interrupt_enable;
	logic [1:0]  timer_run, exp_f;
	wire         external_reset_pin_n, watchdog_overflow;
	int          num_errors = 0, checked = 0, cyc = 0;

	reset_source_model src_u (.clk_sys, .pin_hold, .wd_fire, .external_reset_pin_n,
		.watchdog_overflow);
	reset_state_initialiser dut_u (.clk_sys, .rstn, .ce, .external_reset_pin_n,
		.watchdog_overflow, .power_down, .watchdog_clear, .timeout_flag, .power_down_flag,
		.status_reg, .core_reset, .program_counter, .stack_pointer, .interrupt_enable,
		.timer_run, .port_data, .port_dir, .watchdog_select_reg, .watchdog_counter, .ref_clk,
		.sys_clk_en, .watchdog_osc);

	always #50 clk_sys = ~clk_sys;

	task finish_test;
		$display("errors %0d checks %0d", num_errors, checked);
		if (num_errors == 0 && checked > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	// Hang guard well above the expected run of under a thousand cycles
	always @(posedge clk_sys) begin
		cyc++;
		if (cyc == 8000) begin
			num_errors++;
			finish_test;
		end
	end

	task chk(input logic [11:0] seen, input logic [11:0] exp);
		checked++;
		if (seen !== exp) begin
			num_errors++;
			$display("[ERR] %0t seen %h exp %h", $time, seen, exp);
		end
	endtask

	task wait_core(input logic v);
		int n;
		n = 0;
		while (core_reset !== v && n < 30) begin
			@(negedge clk_sys);
			n++;
		end
		chk(core_reset, v);
	endtask

	// Toggle spacing of a divided clock, after aligning to one toggle
	task period(input bit w, input int exp);
		logic v;
		int n;
		for (int k = 0; k < 2; k++) begin
			v = w ? watchdog_osc : ref_clk;
			n = 0;
			while ((w ? watchdog_osc : ref_clk) === v && n < 400) begin
				@(negedge clk_sys);
				n++;
			end
		end
		chk(12'(n), 12'(exp));
	endtask

	function logic [1:0] flags_after(input logic w, input logic p, input logic [1:0] old);
		return w ? {1'b1, p | old[0]} : old;
	endfunction

	initial begin
		void'($urandom(21350));
		repeat (3) @(negedge clk_sys);
		chk({timeout_flag, power_down_flag, watchdog_counter}, 0);
		rstn <= 1;
		wait_core(0);
		period(0, reset_init_pkg::REF_DIV);
		period(1, reset_init_pkg::WDOG_OSC_DIV);
		exp_f = 0;
		// First four events cover every cause and power-down combination
		for (int i = 0; i < 16; i++) begin
			wd = i < 4 ? i[0] : $urandom % 2;
			pd = i < 4 ? i[1] : $urandom % 2;
			power_down <= pd;
			watchdog_clear <= $urandom % 2;
			if (wd)
				wd_fire <= 1;
			else
				pin_hold <= 1;
			repeat (wd ? 1 : 2 + $urandom % 5) @(negedge clk_sys);
			wd_fire <= 0;
			pin_hold <= 0;
			wait_core(1);
			wait_core(0);
			exp_f = flags_after(wd, pd, exp_f);
			chk({timeout_flag, power_down_flag}, exp_f);
			chk(status_reg, {2'h0, exp_f, 4'h0});
			chk({port_data, port_dir}, 16'hffff);
			chk({interrupt_enable, timer_run}, 0);
			chk(program_counter, 12'h000);
			chk({9'h000, stack_pointer}, {9'h000, reset_init_pkg::SP_TOP});
			chk({4'h0, watchdog_select_reg}, {4'h0, reset_init_pkg::WDT_SEL_RESET});
			// Cleared at the apply step, so at most one tick since
			chk({11'h000, watchdog_counter > 8'h01}, 12'h000);
			// Clock enable follows the core release one cycle later
			@(negedge clk_sys);
			chk({11'h000, sys_clk_en}, {11'h000, ~pd});
		end
		rstn <= 0;
		repeat (3) @(negedge clk_sys);
		chk({timeout_flag, power_down_flag}, 0);
		finish_test;
	end
endmodule // tb
